// File: sim/adc_serial_control_registers_properties.sv
// Port assertions for the serial control register bank.
// Assumes one clock domain with synchronous active-high reset.
module adc_serial_control_registers_properties
  import adc_ctrl_pkg::*;
(
  // Clock, reset and pins
  input wire logic                       clock_in,
  input wire logic                       reset_in,
  input wire logic                       chip_enable_in,
  input wire logic                       serial_enable_n_in,
  // Observed outputs
  input wire logic                       serial_data_io_oe_out,
  input wire logic                       serial_data_out_oe_out,
  input wire logic                       four_wire_out,
  input wire logic [4:0]                 burst_n_out,
  input wire logic                       overrange_flag_out,
  input wire logic                       overrange_out_enable_out,
  input wire adc_ctrl_pkg::sync_mode_t   sync_mode_low_out,
  input wire adc_ctrl_pkg::sync_mode_t   sync_mode_high_out,
  input wire adc_ctrl_pkg::power_state_t power_state_out,
  input wire logic [5:0]                 sleep_code_out,
  input wire logic                       device_awake_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  // Steps of the sleep and serial sequences
  sequence ce_fall;
    $fell(chip_enable_in) && power_state_out == st_run;
  endsequence
  sequence light_wake;
    $rose(power_state_out == st_wake) && sleep_code_out == SLEEP_LIGHT;
  endsequence
  sequence port_idle;
    serial_enable_n_in [*6];
  endsequence

  // Field decodes and output relations
  a_reset_defaults: assert property ($past(reset_in) |-> burst_n_out == 5'h0a
    && !four_wire_out && sync_mode_low_out == sync_pins)
    else $error("defaults missing after reset");
  a_burst_n_range: assert property (burst_n_out inside {[5'h0a:5'h19]})
    else $error("burst length out of range");
  a_sync_low_legal: assert property (sync_mode_low_out != 2'b11)
    else $error("low sync decode illegal");
  a_sync_high_legal: assert property (sync_mode_high_out != 2'b11)
    else $error("high sync decode illegal");
  a_flag_gated: assert property (!overrange_out_enable_out |->
    !overrange_flag_out)
    else $error("flag shown while buffer off");
  a_oe_mode: assert property (serial_data_out_oe_out |-> four_wire_out)
    else $error("output pin driven in three-wire mode");
  a_oe_exclusive: assert property (!(serial_data_io_oe_out &&
    serial_data_out_oe_out))
    else $error("both data pins driven");
  a_oe_idle: assert property (port_idle |-> !serial_data_io_oe_out)
    else $error("data pin driven outside frame");
  a_sleep_entry: assert property (ce_fall |-> ##[1:5]
    power_state_out == st_sleep)
    else $error("sleep not entered");
  a_light_wake: assert property (light_wake |-> ##[1:260]
    device_awake_out)
    else $error("light sleep wake too slow");
  a_awake_state: assert property (device_awake_out ==
    (power_state_out == st_run))
    else $error("awake flag disagrees with state");
endmodule

bind adc_serial_control_registers adc_serial_control_registers_properties
  i_props (.clock_in, .reset_in, .chip_enable_in, .serial_enable_n_in,
    .serial_data_io_oe_out, .serial_data_out_oe_out, .four_wire_out,
    .burst_n_out, .overrange_flag_out, .overrange_out_enable_out,
    .sync_mode_low_out, .sync_mode_high_out, .power_state_out,
    .sleep_code_out, .device_awake_out);

// File: sim/serial_ctl_model.sv
// External controller that runs serial frames on the bank pins.
// Assumes the bank clock is ten times the serial clock or more.
module serial_ctl_model (
  // Pacing clock
  input  wire logic clock_in,
  // Serial pins
  output logic      sclk_out,
  output logic      sen_n_out,
  output logic      sdi_out,
  input  wire logic sdio_in,
  input  wire logic dout_in,
  input  wire logic dout_oe_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // Serial clock idles low between frames
  initial
  begin
    sclk_out = 1'b0;
    sen_n_out = 1'b1;
    sdi_out = 1'b0;
  end

  // One frame: direction bit, address, then sixteen data bits
  task automatic xfer(input logic rd, input logic [6:0] a,
                      input logic [15:0] d, output logic [15:0] q);
    logic [23:0] w;
    w = {rd, a, d};
    @(negedge clock_in) sen_n_out = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      sdi_out = (rd && i < 16) ? ~sdi_out : w[i]; // Released line toggles
      repeat (5) @(negedge clock_in);
      sclk_out = 1'b1;
      q[i % 16] = dout_oe_in ? dout_in : sdio_in;
      repeat (5) @(negedge clock_in);
      sclk_out = 1'b0;
    end
    sen_n_out = 1'b1;
    repeat (4) @(negedge clock_in);
  endtask
endmodule

// File: sim/test_adc_serial_control_registers.sv
// Self-checking bench for the serial control register bank.
// Assumes the controller model paces frames from the bank clock.
module test_adc_serial_control_registers
  import adc_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

`define CHK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); \
    end \
  end

  logic clock_in = 1'b0, reset_in = 1'b1, chip_enable_in = 1'b1;
  logic sclk, sen_n, sdi, sdio_out, sdio_oe, dout, dout_oe, four_wire_out;
  logic out_mode, high_pass, burst_rate, auto_trig, gain_corr, flag;
  logic device_awake_out;
  logic [11:0] sample_in = 12'h000;
  logic [8:0] temperature_in = 9'h000;
  logic [4:0] burst_n_out;
  logic [5:0] sleep_code_out;
  logic [15:0] pins;
  sync_mode_t sync_low, sync_high;
  power_state_t power_state_out;
  int fail_count = 0, checks = 0;
  wire sdio = sdio_oe ? sdio_out : sdi;

  // Clock at 125 MHz
  always #4 clock_in = ~clock_in;

  serial_ctl_model i_ctl (.clock_in, .sclk_out(sclk), .sen_n_out(sen_n),
    .sdi_out(sdi), .sdio_in(sdio), .dout_in(dout), .dout_oe_in(dout_oe));

  adc_serial_control_registers #(.WAKE_SHUTDOWN_CYCLES(40),
    .WAKE_STANDBY_CYCLES(30)) i_dut (.clock_in, .reset_in,
    .serial_clock_in(sclk), .serial_enable_n_in(sen_n),
    .serial_data_io_in(sdio), .serial_data_io_out(sdio_out),
    .serial_data_io_oe_out(sdio_oe), .serial_data_out_out(dout),
    .serial_data_out_oe_out(dout_oe), .serial_reset_n_in(1'b1),
    .chip_enable_in, .sample_in, .temperature_in, .four_wire_out,
    .output_mode_select_out(out_mode), .high_pass_out(high_pass),
    .burst_rate_out(burst_rate), .auto_trigger_out(auto_trig),
    .burst_n_out, .gain_corr_enable_out(gain_corr), .offset_binary_out(),
    .performance_bit_one_out(), .offset_loop_control_out(),
    .overrange_flag_out(flag), .sync_mode_low_out(sync_low),
    .sync_mode_high_out(sync_high), .vref_select_out(),
    .performance_field_two_out(), .buffer_saving_select_out(),
    .temp_sensor_enable_out(), .fuse_bias_enable_out(),
    .sync_buffer_enable_out(), .trigger_buffer_enable_out(),
    .drive_current_code_out(), .drive_range_select_out(),
    .termination_select_out(), .sample_clock_out_enable_out(),
    .overrange_out_enable_out(), .pin_enables_out(pins),
    .power_state_out, .sleep_code_out, .device_awake_out);

  // Verdict and end of run
  task automatic final_report();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Every stored register reads its default
  task automatic chk_defaults();
    logic [15:0] q;
    for (int i = 0; i < NUM_STORED; i++)
    begin
      i_ctl.xfer(1'b1, STORED_ADDR[i], 16'h0000, q);
      `CHK(q, STORED_DEFAULT[i])
    end
  endtask

  // Hang guard
  initial
  begin
    #400000 fail_count++;
    final_report();
  end

  // Main sequence
  initial
  begin
    logic [15:0] d, q;
    logic [5:0] codes [4] = '{6'h00, 6'h20, 6'h30, 6'h35};
    int lims [4] = '{40, 30, 2500, 250};
    int n;
    d = 16'($urandom(32'h9b2d));
    repeat (4) @(negedge clock_in);
    reset_in = 1'b0;
    repeat (3) @(negedge clock_in);
    chk_defaults();
    temperature_in = 9'($urandom);
    i_ctl.xfer(1'b1, ADDR_TEMP, 16'h0000, q);
    `CHK(q, {7'h00, temperature_in})
    // Random words into every stored register except the two sync registers, which take 5554
    for (int i = 0; i < NUM_STORED; i++)
    begin
      d = 16'($urandom);
      if (i == IDX_PWR) d = d | 16'hfe00;
      if (i == IDX_DRV) d[12:11] = {d[15], 1'b1};
      if (i == IDX_SYL || i == IDX_SYH) d = 16'h5554;
      if (i == IDX_BST) d[13:10] = 4'hf;
      if (i == IDX_MODE) d[14] = d[14] | d[12];
      if (i == IDX_OFS) d[14] = 1'b0;
      i_ctl.xfer(1'b0, STORED_ADDR[i], d, q);
      i_ctl.xfer(1'b1, STORED_ADDR[i], 16'h0000, q);
      `CHK(q, d & STORED_MASK[i] | STORED_FIXED[i])
      if (i == IDX_MODE) `CHK({four_wire_out, out_mode, high_pass, burst_rate,
        auto_trig}, {d[15], d[14], d[12], d[5], d[2]})
      if (i == IDX_CORR) `CHK(gain_corr, d[15])
      if (i == IDX_BST) `CHK(burst_n_out, 5'h19)
      if (i == IDX_PINS) `CHK(pins, d)
      if (i == IDX_SYH) `CHK({sync_low, sync_high}, 4'h5)
    end
    i_ctl.xfer(1'b0, ADDR_SOFT_RESET, 16'hd2f0, q);
    chk_defaults();
    i_ctl.xfer(1'b1, ADDR_SOFT_RESET, 16'h0000, q);
    `CHK(q, 16'h0000)
    // Overload just above fifteen sixteenths of full scale
    @(negedge clock_in) sample_in = 12'h781;
    repeat (11) @(posedge clock_in);
    @(negedge clock_in) `CHK(flag, 1'b0)
    @(negedge clock_in) `CHK(flag, 1'b1)
    sample_in = 12'h000;
    // Each sleep state entered and left
    for (int k = 0; k < 4; k++)
    begin
      i_ctl.xfer(1'b0, ADDR_SLEEP, {codes[k], 10'h000}, q);
      chip_enable_in = 1'b0;
      repeat (6) @(negedge clock_in);
      `CHK({power_state_out, sleep_code_out}, {st_sleep, codes[k]})
      chip_enable_in = 1'b1;
      n = 0;
      while (device_awake_out !== 1'b1 && n < 3000)
      begin
        @(negedge clock_in);
        n++;
      end
      `CHK(n <= lims[k] + 5, 1'b1)
    end
    final_report();
  end
endmodule

// File: src/adc_ctrl_pkg.sv
// Constants for the serial control register bank of the converter.
// Assumes one 125 MHz clock; every pin is synchronised in the bank.
//
// Contract
// - Mode bit D15: 0 three-wire shared data pin, 1 four-wire separate output.
// - Mode bit D14: 0 burst output, 1 two-times decimation receive.
// - Mode bit D5: 0 full-rate 9-bit, 1 four-times decimated 11-bit.
// - Mode bit D2: 0 trigger-pin bursts, 1 automatic repeating bursts.
// - Correction bit D15 enables automatic gain correction, default off.
// - Over-range flag rises 12 clocks after the overload occurs.
// - Threshold code D10-D7, trip at full scale times code over 16, default 15.
// - Offset loop bit D14 clears or starts the correction loop, default 1.
// - Sync fields: 00 off, 01 one-shot, 10 sync pins (default), 11 unsupported.
// - Temperature register returns the sensor in D8-D0, upper bits zero.
// - Writing the reset code restores all defaults; register reads zero.
// - Burst length N equals the four-bit code plus ten, default 10.
// - Sleep field picks shutdown, standby, deep or light sleep on enable low.
// - Wake within 2.5 ms, 100 us, 20 us or 2 us by sleep state.
// - Power enables D7-D4 default 1, zero powers down; D3-D0 read ones.
// - Driver bits D15-D13 set 2 mA plus 0.25 mA per step.
// - Driver bits D4 and D1 enable clock and over-range buffers.
// - Pin enable register powers down individual outputs, default all ones.
// - One write updates every field of a register at once.
// - Each access is an 8-bit address with read bit, then 16 data bits.
package adc_ctrl_pkg;

  // Clock rate and sizes
  localparam int CLOCK_MHZ  = 125;
  localparam int NUM_STORED = 12;
  localparam int ADDR_BITS  = 8;
  localparam int FRAME_BITS = 24;

  // Register addresses
  localparam logic [6:0] ADDR_MODE       = 7'h00;
  localparam logic [6:0] ADDR_CORRECTION = 7'h01;
  localparam logic [6:0] ADDR_THRESHOLD  = 7'h02;
  localparam logic [6:0] ADDR_OFFSET     = 7'h03;
  localparam logic [6:0] ADDR_SYNC_LOW   = 7'h0e;
  localparam logic [6:0] ADDR_SYNC_HIGH  = 7'h0f;
  localparam logic [6:0] ADDR_TUNING     = 7'h1a;
  localparam logic [6:0] ADDR_TEMP       = 7'h2b;
  localparam logic [6:0] ADDR_SOFT_RESET = 7'h2c;
  localparam logic [6:0] ADDR_BURST      = 7'h34;
  localparam logic [6:0] ADDR_SLEEP      = 7'h37;
  localparam logic [6:0] ADDR_POWER      = 7'h38;
  localparam logic [6:0] ADDR_DRIVER     = 7'h3a;
  localparam logic [6:0] ADDR_PINS       = 7'h66;

  // Slots of the stored registers
  localparam int IDX_MODE = 0;
  localparam int IDX_CORR = 1;
  localparam int IDX_THR  = 2;
  localparam int IDX_OFS  = 3;
  localparam int IDX_SYL  = 4;
  localparam int IDX_SYH  = 5;
  localparam int IDX_TUNE = 6;
  localparam int IDX_BST  = 7;
  localparam int IDX_SLP  = 8;
  localparam int IDX_PWR  = 9;
  localparam int IDX_DRV  = 10;
  localparam int IDX_PINS = 11;

  // Address, reset value, writable bits and fixed ones per slot
  localparam logic [NUM_STORED-1:0][6:0] STORED_ADDR = {
    ADDR_PINS, ADDR_DRIVER, ADDR_POWER, ADDR_SLEEP, ADDR_BURST,
    ADDR_TUNING, ADDR_SYNC_HIGH, ADDR_SYNC_LOW, ADDR_OFFSET,
    ADDR_THRESHOLD, ADDR_CORRECTION, ADDR_MODE};
  localparam logic [NUM_STORED-1:0][15:0] STORED_DEFAULT = {
    16'hffff, 16'h0812, 16'hffff, 16'h0000, 16'h0000, 16'h4b18,
    16'ha000, 16'haaa8, 16'h4b18, 16'h6780, 16'h0000, 16'h0000};
  localparam logic [NUM_STORED-1:0][15:0] STORED_MASK = {
    16'hffff, 16'hffff, 16'hfff0, 16'hffff, 16'hffff, 16'hffff,
    16'hffff, 16'hffff, 16'hffff, 16'h0780, 16'hffff, 16'hffff};
  localparam logic [NUM_STORED-1:0][15:0] STORED_FIXED = {
    16'h0000, 16'h0000, 16'h000f, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h6000, 16'h0000, 16'h0000};

  // Software reset code
  localparam logic [15:0] SOFT_RESET_CODE = 16'hd2f0;

  // Field positions
  localparam int BIT_FOUR_WIRE   = 15;
  localparam int BIT_OUT_MODE    = 14;
  localparam int BIT_HIGH_PASS   = 12;
  localparam int BIT_BURST_RATE  = 5;
  localparam int BIT_AUTO_TRIG   = 2;
  localparam int BIT_GAIN_CORR   = 15;
  localparam int BIT_DATA_FORMAT = 3;
  localparam int BIT_PERF_ONE    = 1;
  localparam int THR_LSB         = 7;
  localparam int BIT_OFS_LOOP    = 14;
  localparam int SYNC_LSB        = 14;
  localparam int VREF_LSB        = 4;
  localparam int BURST_N_LSB     = 10;
  localparam int SLEEP_LSB       = 10;
  localparam int PERF_TWO_LSB    = 9;
  localparam int BIT_BUF_SAVE    = 8;
  localparam int BIT_TEMP_EN     = 7;
  localparam int BIT_BIAS_EN     = 6;
  localparam int BIT_SYNC_EN     = 5;
  localparam int BIT_TRIG_BUF    = 4;
  localparam int CURRENT_LSB     = 13;
  localparam int RANGE_LSB       = 11;
  localparam int TERM_LSB        = 9;
  localparam int BIT_CLK_OUT_EN  = 4;
  localparam int BIT_RANGE_OUT   = 1;

  // Burst length offset and over-range timing
  localparam logic [4:0] BURST_N_BASE = 5'h0a;
  localparam int FLAG_DELAY = 12;

  // Sleep codes
  localparam logic [5:0] SLEEP_SHUTDOWN = 6'h00;
  localparam logic [5:0] SLEEP_STANDBY  = 6'h20;
  localparam logic [5:0] SLEEP_DEEP     = 6'h30;
  localparam logic [5:0] SLEEP_LIGHT    = 6'h35;

  // Wake-up limits in ns and derived cycle counts (rounded down)
  localparam int WAKE_SHUTDOWN_NS = 2500000;
  localparam int WAKE_STANDBY_NS  = 100000;
  localparam int WAKE_DEEP_NS     = 20000;
  localparam int WAKE_LIGHT_NS    = 2000;
  localparam int WAKE_SHUTDOWN_DEF = WAKE_SHUTDOWN_NS * CLOCK_MHZ / 1000;
  localparam int WAKE_STANDBY_DEF  = WAKE_STANDBY_NS * CLOCK_MHZ / 1000;
  localparam int WAKE_DEEP_CYCLES  = WAKE_DEEP_NS * CLOCK_MHZ / 1000;
  localparam int WAKE_LIGHT_CYCLES = WAKE_LIGHT_NS * CLOCK_MHZ / 1000;

  // Power state of the chip
  typedef enum logic [1:0] {
    st_run   = 2'b00,
    st_sleep = 2'b01,
    st_wake  = 2'b10
  } power_state_t;

  // Decoded synchronisation source
  typedef enum logic [1:0] {
    sync_off  = 2'b00,
    sync_once = 2'b01,
    sync_pins = 2'b10
  } sync_mode_t;

endpackage

// File: src/adc_serial_control_registers.sv
// Serial control register bank of the converter with its sleep sequencer
// and over-range detector. Assumes a 125 MHz system clock well above the
// serial clock; all pins arrive asynchronously and are synchronised here.
module adc_serial_control_registers #(
  parameter int WAKE_SHUTDOWN_CYCLES = adc_ctrl_pkg::WAKE_SHUTDOWN_DEF,
  parameter int WAKE_STANDBY_CYCLES  = adc_ctrl_pkg::WAKE_STANDBY_DEF
)(
  // Clock and reset
  input  wire logic                     clock_in,
  input  wire logic                     reset_in,
  // Serial port pins
  input  wire logic                     serial_clock_in,
  input  wire logic                     serial_enable_n_in,
  input  wire logic                     serial_data_io_in,
  output logic                          serial_data_io_out,
  output logic                          serial_data_io_oe_out,
  output logic                          serial_data_out_out,
  output logic                          serial_data_out_oe_out,
  input  wire logic                     serial_reset_n_in,
  // Chip enable pin
  input  wire logic                     chip_enable_in,
  // Converter samples and sensor
  input  wire logic [11:0]              sample_in,
  input  wire logic [8:0]               temperature_in,
  // Output mode controls
  output logic                          four_wire_out,
  output logic                          output_mode_select_out,
  output logic                          high_pass_out,
  output logic                          burst_rate_out,
  output logic                          auto_trigger_out,
  output logic [4:0]                    burst_n_out,
  // Correction and over-range
  output logic                          gain_corr_enable_out,
  output logic                          offset_binary_out,
  output logic                          performance_bit_one_out,
  output logic                          offset_loop_control_out,
  output logic                          overrange_flag_out,
  // Synchronisation and reference
  output adc_ctrl_pkg::sync_mode_t      sync_mode_low_out,
  output adc_ctrl_pkg::sync_mode_t      sync_mode_high_out,
  output logic [2:0]                    vref_select_out,
  // Power and buffers
  output logic [6:0]                    performance_field_two_out,
  output logic                          buffer_saving_select_out,
  output logic                          temp_sensor_enable_out,
  output logic                          fuse_bias_enable_out,
  output logic                          sync_buffer_enable_out,
  output logic                          trigger_buffer_enable_out,
  // Output drivers
  output logic [2:0]                    drive_current_code_out,
  output logic [1:0]                    drive_range_select_out,
  output logic [1:0]                    termination_select_out,
  output logic                          sample_clock_out_enable_out,
  output logic                          overrange_out_enable_out,
  output logic [15:0]                   pin_enables_out,
  // Sleep sequencer
  output adc_ctrl_pkg::power_state_t    power_state_out,
  output logic [5:0]                    sleep_code_out,
  output logic                          device_awake_out
);
  import adc_ctrl_pkg::*;

  // Slot lookup: bit 4 flags a hit, bits 3:0 give the slot
  function automatic logic [4:0] find_slot(input logic [6:0] a);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < NUM_STORED; i++)
    begin
      if (STORED_ADDR[i] == a)
      begin
        r = {1'b1, i[3:0]};
      end
    end
    return r;
  endfunction

  // Repeated two-bit sync code, unsupported pattern falls back to off
  function automatic sync_mode_t sync_decode(input logic [1:0] code);
    sync_mode_t m;
    case (code)
      2'b00:   m = sync_off;
      2'b01:   m = sync_once;
      2'b10:   m = sync_pins;
      default: m = sync_off;
    endcase
    return m;
  endfunction

  // Wake-up count for a sleep code; unknown codes take the shutdown count
  function automatic logic [18:0] wake_count(input logic [5:0] code);
    logic [18:0] c;
    case (code)
      SLEEP_STANDBY: c = WAKE_STANDBY_CYCLES[18:0];
      SLEEP_DEEP:    c = WAKE_DEEP_CYCLES[18:0];
      SLEEP_LIGHT:   c = WAKE_LIGHT_CYCLES[18:0];
      default:       c = WAKE_SHUTDOWN_CYCLES[18:0];
    endcase
    return c;
  endfunction

  // Pin synchronisers: clock, enable, data, reset, chip enable
  localparam int PIN_SCLK = 0;
  localparam int PIN_CS_N = 1;
  localparam int PIN_SDI  = 2;
  localparam int PIN_RST  = 3;
  localparam int PIN_CE   = 4;
  localparam logic [4:0] PIN_IDLE = 5'h1a;

  logic [4:0] pin_raw;
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic       sclk_last;

  assign pin_raw = {chip_enable_in, serial_reset_n_in, serial_data_io_in,
                    serial_enable_n_in, serial_clock_in};

  // Two flops per pin, then a delayed copy of the clock for edges
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      pin_meta  <= PIN_IDLE;
      pin_sync  <= PIN_IDLE;
      sclk_last <= 1'b0;
    end
    else
    begin
      pin_meta  <= pin_raw;
      pin_sync  <= pin_meta;
      sclk_last <= pin_sync[PIN_SCLK];
    end
  end

  // Named pin levels and serial clock edges
  wire cs_n_s    = pin_sync[PIN_CS_N];
  wire sdi_s     = pin_sync[PIN_SDI];
  wire ce_s      = pin_sync[PIN_CE];
  wire sclk_rise = pin_sync[PIN_SCLK] & ~sclk_last;
  wire sclk_fall = ~pin_sync[PIN_SCLK] & sclk_last;
  wire hard_clear = reset_in | ~pin_sync[PIN_RST];

  // Serial frame state
  logic [4:0]  bit_count;
  logic        read_req;
  logic [6:0]  addr_q;
  logic [15:0] data_shift;
  logic [15:0] read_shift;
  logic        drive_q;

  // Frame decode for the write commit
  wire [15:0] write_data   = {data_shift[14:0], sdi_s};
  wire        write_strobe = ~cs_n_s & sclk_rise & ~read_req &
                             (bit_count == 5'(FRAME_BITS - 1));
  wire        soft_hit     = write_strobe & (addr_q == ADDR_SOFT_RESET) &
                             (write_data == SOFT_RESET_CODE);
  wire        reg_clear    = hard_clear | soft_hit;

  // Address word (read bit first) then data word on rising edges
  always_ff @(posedge clock_in)
  begin
    if (hard_clear | cs_n_s)
    begin
      bit_count  <= 5'h00;
      read_req   <= 1'b0;
      addr_q     <= 7'h00;
      data_shift <= 16'h0000;
    end
    else if (sclk_rise && bit_count < 5'(FRAME_BITS))
    begin
      bit_count <= bit_count + 5'h01;
      if (bit_count == 5'h00)
      begin
        read_req <= sdi_s;
      end
      else if (bit_count < 5'(ADDR_BITS))
      begin
        addr_q <= {addr_q[5:0], sdi_s};
      end
      else
      begin
        data_shift <= write_data;
      end
    end
  end

  // Stored registers, one slot per documented read/write address
  logic [15:0] reg_word [NUM_STORED];
  wire  [4:0]  write_slot = find_slot(addr_q);

  generate
    for (genvar g = 0; g < NUM_STORED; g++)
    begin : gen_reg
      logic [15:0] value;
      // Whole word replaced at once, fixed bits forced
      always_ff @(posedge clock_in)
      begin
        if (reg_clear)
        begin
          value <= STORED_DEFAULT[g];
        end
        else if (write_strobe && write_slot == {1'b1, 4'(g)})
        begin
          value <= (write_data & STORED_MASK[g]) |
                   STORED_FIXED[g];
        end
      end
      assign reg_word[g] = value;
    end
  endgenerate

  // Readback selection; unmapped and write-only addresses read zero
  wire [4:0]  read_slot  = find_slot(addr_q);
  wire [15:0] temp_word  = {7'h00, temperature_in};
  wire [15:0] read_value =
    (addr_q == ADDR_TEMP) ? temp_word :
    read_slot[4]          ? reg_word[read_slot[3:0]] :
                            16'h0000;

  // Read data launched on falling edges after the address word
  always_ff @(posedge clock_in)
  begin
    if (hard_clear | cs_n_s)
    begin
      read_shift <= 16'h0000;
      drive_q    <= 1'b0;
    end
    else if (sclk_fall && read_req && bit_count >= 5'(ADDR_BITS))
    begin
      if (bit_count == 5'(ADDR_BITS))
      begin
        read_shift <= read_value;
        drive_q    <= 1'b1;
      end
      else if (bit_count < 5'(FRAME_BITS))
      begin
        read_shift <= {read_shift[14:0], 1'b0};
      end
      else
      begin
        drive_q <= 1'b0;
      end
    end
  end

  // Shared pin in three-wire mode, dedicated output in four-wire mode
  assign four_wire_out          = reg_word[IDX_MODE][BIT_FOUR_WIRE];
  assign serial_data_io_out     = read_shift[15];
  assign serial_data_out_out    = read_shift[15];
  assign serial_data_io_oe_out  = drive_q & ~four_wire_out;
  assign serial_data_out_oe_out = drive_q & four_wire_out;

  // Output mode fields
  assign output_mode_select_out = reg_word[IDX_MODE][BIT_OUT_MODE];
  assign high_pass_out          = reg_word[IDX_MODE][BIT_HIGH_PASS];
  assign burst_rate_out         = reg_word[IDX_MODE][BIT_BURST_RATE];
  assign auto_trigger_out       = reg_word[IDX_MODE][BIT_AUTO_TRIG];
  assign burst_n_out = {1'b0, reg_word[IDX_BST][BURST_N_LSB +: 4]} +
                       BURST_N_BASE;

  // Correction fields
  assign gain_corr_enable_out    = reg_word[IDX_CORR][BIT_GAIN_CORR];
  assign offset_binary_out       = reg_word[IDX_CORR][BIT_DATA_FORMAT];
  assign performance_bit_one_out = reg_word[IDX_CORR][BIT_PERF_ONE];
  assign offset_loop_control_out = reg_word[IDX_OFS][BIT_OFS_LOOP];

  // Synchronisation and reference fields
  assign sync_mode_low_out  =
    sync_decode(reg_word[IDX_SYL][SYNC_LSB +: 2]);
  assign sync_mode_high_out =
    sync_decode(reg_word[IDX_SYH][SYNC_LSB +: 2]);
  assign vref_select_out    = reg_word[IDX_SYH][VREF_LSB +: 3];

  // Power enables
  assign performance_field_two_out = reg_word[IDX_PWR][PERF_TWO_LSB +: 7];
  assign buffer_saving_select_out  = reg_word[IDX_PWR][BIT_BUF_SAVE];
  assign temp_sensor_enable_out    = reg_word[IDX_PWR][BIT_TEMP_EN];
  assign fuse_bias_enable_out      = reg_word[IDX_PWR][BIT_BIAS_EN];
  assign sync_buffer_enable_out    = reg_word[IDX_PWR][BIT_SYNC_EN];
  assign trigger_buffer_enable_out = reg_word[IDX_PWR][BIT_TRIG_BUF];

  // Output driver fields
  assign drive_current_code_out = reg_word[IDX_DRV][CURRENT_LSB +: 3];
  assign drive_range_select_out = reg_word[IDX_DRV][RANGE_LSB +: 2];
  assign termination_select_out = reg_word[IDX_DRV][TERM_LSB +: 2];
  assign sample_clock_out_enable_out =
    reg_word[IDX_DRV][BIT_CLK_OUT_EN];
  assign overrange_out_enable_out =
    reg_word[IDX_DRV][BIT_RANGE_OUT];
  assign pin_enables_out = reg_word[IDX_PINS];

  // Over-range: two's complement magnitude against code/16 of full scale
  logic [FLAG_DELAY-1:0] range_pipe;
  wire  [11:0] sample_neg = 12'(~sample_in + 12'h001);
  wire  [11:0] sample_mag = sample_in[11] ? sample_neg : sample_in;
  wire  [11:0] trip_level =
    {1'b0, reg_word[IDX_THR][THR_LSB +: 4], 7'h00};
  wire         overload   = sample_mag > trip_level;

  // Delay line so the flag appears a fixed number of clocks later
  always_ff @(posedge clock_in)
  begin
    if (hard_clear)
    begin
      range_pipe <= '0;
    end
    else
    begin
      range_pipe <= {range_pipe[FLAG_DELAY-2:0], overload};
    end
  end

  assign overrange_flag_out = range_pipe[FLAG_DELAY-1] &
                              overrange_out_enable_out;

  // Sleep sequencer state
  power_state_t state;
  power_state_t next_state;
  logic [5:0]   sleep_code;
  logic [18:0]  wake_left;
  logic [18:0]  next_wake_left;
  wire  [5:0]   sleep_field = reg_word[IDX_SLP][SLEEP_LSB +: 6];

  // Next-state logic: enable low sleeps, enable high wakes after a count
  always_comb
  begin
    next_state     = state;
    next_wake_left = wake_left;
    case (state)
      st_run:
      begin
        if (!ce_s)
        begin
          next_state = st_sleep;
        end
      end
      st_sleep:
      begin
        if (ce_s)
        begin
          next_state     = st_wake;
          next_wake_left = wake_count(sleep_code);
        end
      end
      st_wake:
      begin
        if (!ce_s)
        begin
          next_state = st_sleep;
        end
        else if (wake_left <= 19'h00001)
        begin
          next_state = st_run;
        end
        else
        begin
          next_wake_left = wake_left - 19'h00001;
        end
      end
      default:
      begin
        next_state = st_run;
      end
    endcase
  end

  // State registers; sleep kind captured as enable falls
  always_ff @(posedge clock_in)
  begin
    if (hard_clear)
    begin
      state      <= st_run;
      wake_left  <= 19'h00000;
      sleep_code <= SLEEP_SHUTDOWN;
    end
    else
    begin
      state     <= next_state;
      wake_left <= next_wake_left;
      if (state == st_run && !ce_s)
      begin
        sleep_code <= sleep_field;
      end
    end
  end

  assign power_state_out  = state;
  assign sleep_code_out   = sleep_code;
  assign device_awake_out = (state == st_run);

endmodule
